// *** serial_port_pkg.sv ***
// shared constants for the async serial control port
package serial_port_pkg;
  // command word bit positions
  localparam int CMD_TX_ENABLE = 0;
  localparam int CMD_TERM_READY = 1;
  localparam int CMD_RX_ENABLE = 2;
  localparam int CMD_SEND_BREAK = 3;
  localparam int CMD_FAULT_CLEAR = 4;
  localparam int CMD_REQ_SEND = 5;
  localparam int CMD_INTERNAL_RESET = 6;
  localparam int CMD_HUNT_MODE = 7;
  // mode word fields
  localparam int MODE_FACTOR_LSB = 0;
  localparam int MODE_LEN_LSB = 2;
  localparam int MODE_PAR_EN = 4;
  localparam int MODE_PAR_EVEN = 5;
  localparam int MODE_STOP_LSB = 6;
  localparam logic [1:0] FACTOR_X16 = 2'h2;
  localparam logic [1:0] FACTOR_X64 = 2'h3;
  localparam logic [1:0] STOP_TWO = 2'h3;
  // status word bit positions
  localparam int ST_TX_READY = 0;
  localparam int ST_RX_READY = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_PARITY_ERR = 3;
  localparam int ST_OVERRUN_ERR = 4;
  localparam int ST_FRAMING_ERR = 5;
  localparam int ST_CTS = 7;
  // reset values, fifo depth and state encodings
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [6:0] DIV_RESET = 7'h00;
  localparam int TX_FIFO_DEPTH = 4;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage

// *** char_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  // ****************************************
  // handshake
  // ****************************************
  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_ff];

  // storage has no reset, only pointers and count do
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** async_serial_control_port.sv ***
// async serial transceiver channel with mode/command programming
`timescale 1ns/100ps
`default_nettype none
module async_serial_control_port #(
  parameter int FIFO_DEPTH = serial_port_pkg::TX_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic host_cs,
  input wire logic host_cmd_sel,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic tx_hold_ready,
  output logic rx_char_ready,
  input wire logic tx_bit_clock,
  input wire logic rx_bit_clock,
  output logic txd,
  input wire logic rxd,
  input wire logic cts_n,
  output logic rts_n,
  output logic dtr_n
);
  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [6:0] bit_factor(input logic [1:0] code);
    case (code)
      serial_port_pkg::FACTOR_X16: bit_factor = 7'h10;
      serial_port_pkg::FACTOR_X64: bit_factor = 7'h40;
      default: bit_factor = 7'h01;
    endcase
  endfunction

  logic [7:0] mode_ff;
  logic [7:0] cmd_ff;
  logic mode_loaded_ff;
  logic [7:0] hold_ff;
  logic hold_full_ff;
  logic [7:0] rx_buf_ff;
  logic rx_full_ff;
  logic par_err_ff;
  logic ovr_err_ff;
  logic frm_err_ff;
  logic [7:0] rdata_ff;
  logic txd_ff;
  logic rts_n_ff;
  logic dtr_n_ff;

  logic ctl_wr;
  logic data_wr;
  logic ctl_rd;
  logic data_rd;
  logic soft_rst;
  logic fault_clear;
  logic [6:0] factor;
  logic [2:0] last_bit;
  logic par_en;
  logic par_even;
  logic [7:0] len_mask;

  assign ctl_wr = host_cs & host_wr & host_cmd_sel;
  assign data_wr = host_cs & host_wr & ~host_cmd_sel;
  assign ctl_rd = host_cs & host_rd & host_cmd_sel;
  assign data_rd = host_cs & host_rd & ~host_cmd_sel;
  // a command write with its reset bit set
  assign soft_rst = ctl_wr & mode_loaded_ff & host_wdata[serial_port_pkg::CMD_INTERNAL_RESET];
  assign fault_clear = ctl_wr & mode_loaded_ff & host_wdata[serial_port_pkg::CMD_FAULT_CLEAR];
  assign factor = bit_factor(mode_ff[serial_port_pkg::MODE_FACTOR_LSB +: 2]);
  assign last_bit = {1'b1, mode_ff[serial_port_pkg::MODE_LEN_LSB +: 2]};
  assign par_en = mode_ff[serial_port_pkg::MODE_PAR_EN];
  assign par_even = mode_ff[serial_port_pkg::MODE_PAR_EVEN];
  assign len_mask = 8'hFF >> (3'h3 - mode_ff[serial_port_pkg::MODE_LEN_LSB +: 2]);

  // ****************************************
  // programming sequence
  // ****************************************
  // mode word is only ever replaced right after a reset of either kind
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mode_ff <= serial_port_pkg::MODE_RESET;
      mode_loaded_ff <= 1'b0;
    end else if (ctl_wr && !mode_loaded_ff) begin
      mode_ff <= host_wdata;
      mode_loaded_ff <= 1'b1;
    end else if (soft_rst) begin
      mode_loaded_ff <= 1'b0;
    end
  end

  // command word; hunt bit is stored but asynchronous framing ignores it
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cmd_ff <= serial_port_pkg::CMD_RESET;
    end else if (soft_rst) begin
      cmd_ff <= serial_port_pkg::CMD_RESET;
    end else if (ctl_wr && mode_loaded_ff) begin
      cmd_ff <= host_wdata;
    end
  end

  // modem controls are low-active copies of the command bits
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rts_n_ff <= 1'b1;
      dtr_n_ff <= 1'b1;
    end else begin
      rts_n_ff <= ~cmd_ff[serial_port_pkg::CMD_REQ_SEND];
      dtr_n_ff <= ~cmd_ff[serial_port_pkg::CMD_TERM_READY];
    end
  end

  // ****************************************
  // transmit holding register and fifo
  // ****************************************
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;

  // unused high bits are dropped on the way in
  always_ff @(posedge core_clk) begin
    if (!resetn || soft_rst) begin
      hold_full_ff <= 1'b0;
      hold_ff <= 8'h00;
    end else if (data_wr && mode_loaded_ff && !hold_full_ff) begin
      hold_full_ff <= 1'b1;
      hold_ff <= host_wdata & len_mask;
    end else if (hold_full_ff && fifo_in_ready) begin
      hold_full_ff <= 1'b0;
    end
  end

  assign tx_hold_ready = mode_loaded_ff & ~hold_full_ff;

  char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(hold_full_ff),
    .in_ready(fifo_in_ready),
    .in_data(hold_ff),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ****************************************
  // transmitter
  // ****************************************
  serial_port_pkg::tx_state_t tx_state_ff;
  logic tx_clk_q_ff;
  logic [6:0] tx_div_ff;
  logic tx_tick;
  logic [7:0] tx_sh_ff;
  logic tx_par_ff;
  logic [2:0] tx_cnt_ff;
  logic tx_line_ff;
  logic tx_go;

  // divider counts falling edges of the bit clock
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_clk_q_ff <= 1'b1;
      tx_div_ff <= serial_port_pkg::DIV_RESET;
    end else begin
      tx_clk_q_ff <= tx_bit_clock;
      if (tx_clk_q_ff && !tx_bit_clock) begin
        tx_div_ff <= (tx_div_ff >= factor - 7'h01) ? 7'h00 : tx_div_ff + 7'h01;
      end
    end
  end

  assign tx_tick = tx_clk_q_ff & ~tx_bit_clock & (tx_div_ff >= factor - 7'h01);
  // start only with enable and clear to send both present
  assign tx_go = fifo_out_valid & cmd_ff[serial_port_pkg::CMD_TX_ENABLE] & ~cts_n;
  assign fifo_out_ready = tx_tick & tx_go &
    ((tx_state_ff == serial_port_pkg::TX_IDLE) ||
     (tx_state_ff == serial_port_pkg::TX_STOP &&
      tx_cnt_ff == {2'b00, mode_ff[serial_port_pkg::MODE_STOP_LSB +: 2] == serial_port_pkg::STOP_TWO}));

  // frame sequencer, every change lands on a bit tick
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_state_ff <= serial_port_pkg::TX_IDLE;
      tx_line_ff <= 1'b1;
      tx_sh_ff <= 8'h00;
      tx_par_ff <= 1'b0;
      tx_cnt_ff <= 3'h0;
    end else if (fifo_out_ready) begin
      tx_state_ff <= serial_port_pkg::TX_START;
      tx_line_ff <= 1'b0;
      tx_sh_ff <= fifo_out_data;
      tx_par_ff <= par_even ? ^fifo_out_data : ~^fifo_out_data;
    end else if (tx_tick) begin
      case (tx_state_ff)
        serial_port_pkg::TX_START: begin
          tx_line_ff <= tx_sh_ff[0];
          tx_sh_ff <= tx_sh_ff >> 1;
          tx_cnt_ff <= 3'h0;
          tx_state_ff <= serial_port_pkg::TX_DATA;
        end
        serial_port_pkg::TX_DATA: begin
          if (tx_cnt_ff == last_bit) begin
            tx_cnt_ff <= 3'h0;
            tx_line_ff <= par_en ? tx_par_ff : 1'b1;
            tx_state_ff <= par_en ? serial_port_pkg::TX_PAR : serial_port_pkg::TX_STOP;
          end else begin
            tx_line_ff <= tx_sh_ff[0];
            tx_sh_ff <= tx_sh_ff >> 1;
            tx_cnt_ff <= tx_cnt_ff + 3'h1;
          end
        end
        serial_port_pkg::TX_PAR: begin
          tx_line_ff <= 1'b1;
          tx_state_ff <= serial_port_pkg::TX_STOP;
        end
        serial_port_pkg::TX_STOP: begin
          if (tx_cnt_ff == {2'b00, mode_ff[serial_port_pkg::MODE_STOP_LSB +: 2] ==
                            serial_port_pkg::STOP_TWO}) begin
            tx_state_ff <= serial_port_pkg::TX_IDLE;
          end else begin
            tx_cnt_ff <= tx_cnt_ff + 3'h1;
          end
        end
        default: begin
          tx_line_ff <= 1'b1;
          tx_state_ff <= serial_port_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // break overrides the frame; output is registered so it never glitches
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      txd_ff <= 1'b1;
    end else begin
      txd_ff <= cmd_ff[serial_port_pkg::CMD_SEND_BREAK] ? 1'b0 : tx_line_ff;
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  serial_port_pkg::rx_state_t rx_state_ff;
  logic rx_clk_q_ff;
  logic rx_rise;
  logic rx_line_q_ff;
  logic rx_armed_ff;
  logic [6:0] rx_div_ff;
  logic [6:0] rx_tgt_ff;
  logic rx_centre;
  logic [7:0] rx_sh_ff;
  logic [2:0] rx_cnt_ff;
  logic rx_done;
  logic rx_par_bad;
  logic rx_frm_bad;
  logic rx_en;

  assign rx_en = cmd_ff[serial_port_pkg::CMD_RX_ENABLE];
  assign rx_rise = ~rx_clk_q_ff & rx_bit_clock;
  assign rx_centre = rx_rise & (rx_state_ff != serial_port_pkg::RX_IDLE) &
    (rx_div_ff == rx_tgt_ff - 7'h01);
  assign rx_done = rx_centre & (rx_state_ff == serial_port_pkg::RX_STOP);
  assign rx_frm_bad = rx_done & ~rxd;
  assign rx_par_bad = rx_centre & (rx_state_ff == serial_port_pkg::RX_PAR) &
    (rxd != (par_even ? ^rx_sh_ff : ~^rx_sh_ff));

  // line history and the idle-high check that arms start detection
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_clk_q_ff <= 1'b0;
      rx_line_q_ff <= 1'b0;
      rx_armed_ff <= 1'b0;
    end else begin
      rx_clk_q_ff <= rx_bit_clock;
      if (rx_rise) begin
        rx_line_q_ff <= rxd;
        if (rxd) begin
          rx_armed_ff <= 1'b1;
        end
      end
    end
  end

  // bit-centre counter: half a bit to the start centre, then whole bits
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_state_ff <= serial_port_pkg::RX_IDLE;
      rx_div_ff <= serial_port_pkg::DIV_RESET;
      rx_tgt_ff <= 7'h01;
      rx_sh_ff <= 8'h00;
      rx_cnt_ff <= 3'h0;
    end else if (rx_rise) begin
      if (rx_state_ff == serial_port_pkg::RX_IDLE) begin
        if (rx_en && rx_armed_ff && rx_line_q_ff && !rxd) begin
          rx_div_ff <= 7'h00;
          rx_sh_ff <= 8'h00;
          rx_cnt_ff <= 3'h0;
          // 1x has no sub-bit timing, so the edge itself is taken as valid
          rx_tgt_ff <= (factor == 7'h01) ? 7'h01 : factor >> 1;
          rx_state_ff <= (factor == 7'h01) ? serial_port_pkg::RX_DATA :
                         serial_port_pkg::RX_START;
        end
      end else if (!rx_centre) begin
        rx_div_ff <= rx_div_ff + 7'h01;
      end else begin
        rx_div_ff <= 7'h00;
        rx_tgt_ff <= factor;
        case (rx_state_ff)
          serial_port_pkg::RX_START: begin
            // a spike that is gone by mid-bit is dropped
            rx_state_ff <= rxd ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
          end
          serial_port_pkg::RX_DATA: begin
            rx_sh_ff[rx_cnt_ff] <= rxd;
            rx_cnt_ff <= rx_cnt_ff + 3'h1;
            if (rx_cnt_ff == last_bit) begin
              rx_state_ff <= par_en ? serial_port_pkg::RX_PAR : serial_port_pkg::RX_STOP;
            end
          end
          serial_port_pkg::RX_PAR: begin
            rx_state_ff <= serial_port_pkg::RX_STOP;
          end
          default: begin
            rx_state_ff <= serial_port_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // receive buffer; a load beats a same-cycle read
  always_ff @(posedge core_clk) begin
    if (!resetn || soft_rst) begin
      rx_buf_ff <= 8'h00;
      rx_full_ff <= 1'b0;
    end else if (rx_done) begin
      rx_buf_ff <= rx_sh_ff;
      rx_full_ff <= 1'b1;
    end else if (data_rd) begin
      rx_full_ff <= 1'b0;
    end
  end

  assign rx_char_ready = rx_full_ff & rx_en;

  // error flags: a new error wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!resetn || soft_rst) begin
      par_err_ff <= 1'b0;
      ovr_err_ff <= 1'b0;
      frm_err_ff <= 1'b0;
    end else begin
      par_err_ff <= rx_par_bad | (par_err_ff & ~fault_clear);
      ovr_err_ff <= (rx_done & rx_full_ff) | (ovr_err_ff & ~fault_clear);
      frm_err_ff <= rx_frm_bad | (frm_err_ff & ~fault_clear);
    end
  end

  // ****************************************
  // host read data
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else if (data_rd) begin
      rdata_ff <= rx_buf_ff;
    end else if (ctl_rd) begin
      rdata_ff <= 8'h00;
      rdata_ff[serial_port_pkg::ST_TX_READY] <= tx_hold_ready;
      rdata_ff[serial_port_pkg::ST_RX_READY] <= rx_char_ready;
      rdata_ff[serial_port_pkg::ST_TX_EMPTY] <= ~hold_full_ff & ~fifo_out_valid &
        (tx_state_ff == serial_port_pkg::TX_IDLE);
      rdata_ff[serial_port_pkg::ST_PARITY_ERR] <= par_err_ff;
      rdata_ff[serial_port_pkg::ST_OVERRUN_ERR] <= ovr_err_ff;
      rdata_ff[serial_port_pkg::ST_FRAMING_ERR] <= frm_err_ff;
      rdata_ff[serial_port_pkg::ST_CTS] <= ~cts_n;
    end
  end

  assign host_rdata = rdata_ff;
  assign txd = txd_ff;
  assign rts_n = rts_n_ff;
  assign dtr_n = dtr_n_ff;
endmodule
`default_nettype wire

// *** async_serial_control_port_properties.sv ***
// port-level checker for the async serial control port
`timescale 1ns/100ps
`default_nettype none
module async_serial_control_port_properties (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic host_cs,
  input wire logic host_cmd_sel,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic tx_hold_ready,
  input wire logic rx_char_ready,
  input wire logic tx_bit_clock,
  input wire logic rx_bit_clock,
  input wire logic txd,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic dtr_n
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  sequence s_data_wr;
    host_cs && host_wr && !host_cmd_sel && tx_hold_ready;
  endsequence
  sequence s_data_rd;
    host_cs && host_rd && !host_cmd_sel && rx_char_ready;
  endsequence
  // reset checks stay live while reset is held, so no disable here
  property p_reset_line;
    !resetn |=> txd && rts_n && dtr_n;
  endproperty
  a_reset_line: assert property (p_reset_line)
    else $error("line outputs not idle after reset");
  property p_reset_ready;
    !resetn |=> !tx_hold_ready && !rx_char_ready && host_rdata == 8'h00;
  endproperty
  a_reset_ready: assert property (p_reset_ready)
    else $error("ready flags or read data set in reset");
  property p_tx_clear;
    disable iff (!resetn) s_data_wr |=> !tx_hold_ready;
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("tx hold ready not cleared by data write");
  property p_rx_clear;
    disable iff (!resetn) s_data_rd |=> !rx_char_ready;
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("rx char ready not cleared by data read");
  // command register then modem register: the line moves two samples after the write
  property p_rts_cause;
    disable iff (!resetn) $changed(rts_n) |-> $past(host_cs && host_wr && host_cmd_sel, 2);
  endproperty
  a_rts_cause: assert property (p_rts_cause)
    else $error("rts changed without a control write");
  property p_dtr_cause;
    disable iff (!resetn) $changed(dtr_n) |-> $past(host_cs && host_wr && host_cmd_sel, 2);
  endproperty
  a_dtr_cause: assert property (p_dtr_cause)
    else $error("dtr changed without a control write");
  // a tx bit may only move after a sampled tx clock fall; break follows a write
  property p_txd_timing;
    disable iff (!resetn) $changed(txd) |->
      ($past(tx_bit_clock, 3) && !$past(tx_bit_clock, 2)) ||
      ($past(tx_bit_clock, 4) && !$past(tx_bit_clock, 3)) ||
      $past(host_wr, 1) || $past(host_wr, 2) || $past(host_wr, 3);
  endproperty
  a_txd_timing: assert property (p_txd_timing)
    else $error("txd moved off the tx clock fall");
  property p_rdata_cause;
    disable iff (!resetn) $changed(host_rdata) |-> $past(host_cs && host_rd);
  endproperty
  a_rdata_cause: assert property (p_rdata_cause)
    else $error("read data changed without a read");
endmodule
bind async_serial_control_port async_serial_control_port_properties
  async_serial_control_port_properties_i (
  .core_clk(core_clk), .resetn(resetn), .host_cs(host_cs), .host_cmd_sel(host_cmd_sel),
  .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
  .tx_hold_ready(tx_hold_ready), .rx_char_ready(rx_char_ready),
  .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock), .txd(txd), .rxd(rxd),
  .cts_n(cts_n), .rts_n(rts_n), .dtr_n(dtr_n));
`default_nettype wire

// *** host_cpu.sv ***
// host processor model driving the control/data bus
`timescale 1ns/100ps
`default_nettype none
module host_cpu (
  input wire logic core_clk,
  output var logic host_cs,
  output var logic host_cmd_sel,
  output var logic host_wr,
  output var logic host_rd,
  output var logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    host_cs = 1'b0;
    host_cmd_sel = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end
  // one-cycle strobe, held across the taking edge, released after it
  task automatic put(input logic sel, input logic [7:0] d);
    @(negedge core_clk);
    host_cs = 1'b1;
    host_cmd_sel = sel;
    host_wr = 1'b1;
    host_wdata = d;
    @(negedge core_clk);
    host_cs = 1'b0;
    host_wr = 1'b0;
  endtask
  // read data is registered, so it is taken one cycle after the strobe
  task automatic get(input logic sel, output logic [7:0] d);
    @(negedge core_clk);
    host_cs = 1'b1;
    host_cmd_sel = sel;
    host_rd = 1'b1;
    @(negedge core_clk);
    host_cs = 1'b0;
    host_rd = 1'b0;
    d = host_rdata;
  endtask
  // callers issue this before any command after every reset
  task automatic mode(input logic [7:0] d);
    put(1'b1, d);
  endtask
  task automatic command(input logic [7:0] d);
    logic [7:0] c;
    c = d;
    c[4] = c[4] | d[serial_port_pkg::CMD_RX_ENABLE] | d[serial_port_pkg::CMD_HUNT_MODE];
    put(1'b1, c);
  endtask
endmodule
`default_nettype wire

// *** tb_async_serial_control_port.sv ***
// self-checking bench for the async serial control port
`timescale 1ns/100ps
`default_nettype none
module tb_async_serial_control_port;
  localparam logic [7:0] MODE_8E = 8'h3C;
  localparam logic [7:0] CMD_RUN = 8'h37;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic tclk = 1'b0;
  logic rclk = 1'b1;
  logic [1:0] bcnt = 2'h0;
  logic loop_en = 1'b1;
  logic rx_drv = 1'b1;
  logic cts_n = 1'b1;
  logic host_cs, host_cmd_sel, host_wr, host_rd;
  logic [7:0] host_wdata, host_rdata, s;
  logic [10:0] f;
  logic tx_hold_ready, rx_char_ready, txd, rts_n, dtr_n;
  wire logic rxd = loop_en ? txd : rx_drv;
  int miscompares = 0;
  int n_tests = 0;
  // ****************************************
  // clocks and instances
  // ****************************************
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // rx clock is the inverse of tx so looped bits are sampled mid-cell
  always @(negedge core_clk) begin
    bcnt <= bcnt + 2'h1;
    tclk <= bcnt[1];
    rclk <= ~bcnt[1];
  end
  host_cpu host_cpu_i (.core_clk(core_clk), .host_cs(host_cs), .host_cmd_sel(host_cmd_sel),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata));
  async_serial_control_port async_serial_control_port_i (.core_clk(core_clk),
    .resetn(resetn), .host_cs(host_cs), .host_cmd_sel(host_cmd_sel), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .tx_hold_ready(tx_hold_ready), .rx_char_ready(rx_char_ready), .tx_bit_clock(tclk),
    .rx_bit_clock(rclk), .txd(txd), .rxd(rxd), .cts_n(cts_n), .rts_n(rts_n), .dtr_n(dtr_n));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // bounded search for the start bit, then one sample per bit centre
  task automatic get_frame(output logic [10:0] fr);
    for (int i = 0; i < 400 && txd !== 1'b0; i++) @(negedge core_clk);
    @(negedge core_clk);
    for (int b = 0; b < 11; b++) begin
      if (b > 0) repeat (4) @(negedge core_clk);
      fr[b] = txd;
    end
  endtask
  task automatic wait_rx(input int lim = 200);
    for (int i = 0; i < lim && rx_char_ready !== 1'b1; i++) @(negedge core_clk);
    check("rx_char_ready", rx_char_ready, 1'b1);
  endtask
  // bits change one core cycle after the rx clock falls, then the line returns high
  task automatic send_rx(input logic [10:0] fr);
    for (int b = 0; b < 12; b++) begin
      @(negedge core_clk iff bcnt == 2'h3);
      rx_drv = (b < 11) ? fr[b] : 1'b1;
    end
    wait_rx();
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check("idle lines", {txd, rts_n, dtr_n}, 3'h7);
    host_cpu_i.put(1'b0, 8'h55);
    repeat (3) @(negedge core_clk);
    check("hold ready before mode", tx_hold_ready, 1'b0);
  endtask
  task automatic t_program(input logic [7:0] m);
    host_cpu_i.mode(m);
    host_cpu_i.command(CMD_RUN);
    @(negedge core_clk);
    check("hold ready", tx_hold_ready, 1'b1);
    check("modem lines", {rts_n, dtr_n}, 2'h0);
  endtask
  task automatic t_frame(input logic [7:0] d);
    cts_n = 1'b1;
    host_cpu_i.put(1'b0, d);
    check("hold ready cleared", tx_hold_ready, 1'b0);
    repeat (40) @(negedge core_clk);
    check("txd without cts", txd, 1'b1);
    cts_n = 1'b0;
    get_frame(f);
    check("tx frame", f, {1'b1, ^d, d, 1'b0});
    wait_rx();
    host_cpu_i.get(1'b0, s);
    check("rx data", s, d);
    check("rx ready cleared", rx_char_ready, 1'b0);
  endtask
  task automatic t_overrun();
    host_cpu_i.put(1'b0, 8'h11);
    host_cpu_i.put(1'b0, 8'h22);
    get_frame(f);
    get_frame(f);
    check("second frame", f, {1'b1, ^8'h22, 8'h22, 1'b0});
    repeat (3) @(negedge core_clk);
    host_cpu_i.get(1'b1, s);
    check("overrun flag", s[serial_port_pkg::ST_OVERRUN_ERR], 1'b1);
    host_cpu_i.get(1'b0, s);
    check("overrun data", s, 8'h22);
    host_cpu_i.command(CMD_RUN);
    host_cpu_i.get(1'b1, s);
    check("flags cleared", s[5:3], 3'h0);
  endtask
  task automatic t_rx_errors();
    loop_en = 1'b0;
    send_rx({1'b1, ~^8'h3C, 8'h3C, 1'b0});
    host_cpu_i.get(1'b1, s);
    check("parity err", {s[serial_port_pkg::ST_PARITY_ERR], s[5]}, 2'h2);
    host_cpu_i.get(1'b0, s);
    check("parity char", s, 8'h3C);
    host_cpu_i.command(CMD_RUN);
    send_rx({1'b0, ^8'hC3, 8'hC3, 1'b0});
    host_cpu_i.get(1'b1, s);
    check("framing err", s[serial_port_pkg::ST_FRAMING_ERR], 1'b1);
    host_cpu_i.get(1'b0, s);
    check("framed char", s, 8'hC3);
    host_cpu_i.command(CMD_RUN);
    loop_en = 1'b1;
  endtask
  // loop is opened during the break so the receiver never frames it
  task automatic t_break_mask();
    loop_en = 1'b0;
    host_cpu_i.command(8'h3F);
    repeat (20) @(negedge core_clk);
    check("break low", txd, 1'b0);
    host_cpu_i.command(CMD_RUN);
    repeat (4) @(negedge core_clk);
    check("break off", txd, 1'b1);
    loop_en = 1'b1;
    host_cpu_i.put(1'b0, 8'h5A);
    wait_rx();
    host_cpu_i.command(8'h33);
    @(negedge core_clk);
    check("rx masked", rx_char_ready, 1'b0);
    host_cpu_i.command(CMD_RUN);
    check("rx unmasked", rx_char_ready, 1'b1);
    host_cpu_i.get(1'b0, s);
    check("kept char", s, 8'h5A);
  endtask
  task automatic t_short();
    host_cpu_i.command(8'h40);
    @(negedge core_clk);
    check("hold ready after internal reset", tx_hold_ready, 1'b0);
    t_program(8'h00);
    host_cpu_i.put(1'b0, 8'hFF);
    wait_rx();
    host_cpu_i.get(1'b0, s);
    check("short char", s, 8'h1F);
  endtask
  // 16x, no parity, two stops; a short low spike must not start a character
  task automatic t_fast();
    host_cpu_i.command(8'h40);
    t_program(8'hCE);
    loop_en = 1'b0;
    @(negedge core_clk iff bcnt == 2'h3);
    rx_drv = 1'b0;
    repeat (8) @(negedge core_clk);
    rx_drv = 1'b1;
    repeat (760) @(negedge core_clk);
    check("spike ignored", rx_char_ready, 1'b0);
    loop_en = 1'b1;
    host_cpu_i.put(1'b0, 8'h96);
    wait_rx(1000);
    host_cpu_i.get(1'b1, s);
    check("16x flags", s[5:3], 3'h0);
    host_cpu_i.get(1'b0, s);
    check("16x char", s, 8'h96);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    t_reset();
    t_program(MODE_8E);
    t_frame(8'hA5);
    t_overrun();
    t_rx_errors();
    t_break_mask();
    t_short();
    t_fast();
    tally_and_finish();
  end
endmodule
`default_nettype wire
